// ---- msps_consts.svh ----
`ifndef MSPS_CONSTS_SVH
`define MSPS_CONSTS_SVH

// ***************************************************************
// Register bus shape
// ***************************************************************
`define MSPS_AW 8
`define MSPS_DW 32
`define MSPS_DATA_ZERO 32'h0000_0000

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define MSPS_ADDR_CTRL 8'h00
`define MSPS_ADDR_GPIO_DIR 8'h04
`define MSPS_ADDR_GPIO_OUT 8'h08
`define MSPS_ADDR_GPIO_IN 8'h0c
`define MSPS_ADDR_STATUS 8'h10

// ***************************************************************
// Field positions
// ***************************************************************
`define MSPS_CTRL_FORCE_BIT 0
`define MSPS_GPIO_W 2
`define MSPS_IO3_BIT 0
`define MSPS_IO4_BIT 1
`define MSPS_ST_SCL_PULLUP 0
`define MSPS_ST_CLK66_STRAP 1
`define MSPS_ST_M66EN 2
`define MSPS_ST_SB_MODE 3
`define MSPS_ST_SERIAL_IRQ_PIN_EN 4
`define MSPS_ST_VALID 5
`define MSPS_ST_MHZ_LO 8
`define MSPS_ST_MHZ_HI 14

// ***************************************************************
// Reset values
// ***************************************************************
`define MSPS_FORCE_RST 1'b0
`define MSPS_GPIO_RST 2'h0
`define MSPS_BIT_CLR 1'b0
`define MSPS_BIT_SET 1'b1

// ***************************************************************
// Clock frequencies in MHz
// ***************************************************************
`define MSPS_MHZ_W 7
`define MSPS_PCLK_LOW_MHZ 7'h32
`define MSPS_PCLK_HIGH_MHZ 7'h42

// ***************************************************************
// Synchroniser lanes
// ***************************************************************
`define MSPS_SYNC_W 7
`define MSPS_SY_GLOBAL_RESET_N 0
`define MSPS_SY_IO3 1
`define MSPS_SY_IO4 2
`define MSPS_SY_CLK66 3
`define MSPS_SY_M66EN 4
`define MSPS_SY_SERIAL_IRQ_PIN 5
`define MSPS_SY_LRST 6
`define MSPS_STRAP_W 3

`endif

// ---- msps_pkg.sv ----
package msps_pkg;

   // Straps caught once after global reset release
   typedef struct packed
   {
      logic scl_pullup;
      logic clk66;
      logic m66en;
   } msps_strap_t;

   // Drive of one shared terminal
   typedef struct packed
   {
      logic out;
      logic oe;
   } msps_pin_t;

   // Strap sampling phase after reset
   typedef enum logic [1:0]
   {
      MSPS_HELD_RESET,
      MSPS_SAMPLE,
      MSPS_RUN
   } msps_phase_t;

endpackage

// ---- msps_sync.sv ----
`timescale 1ns/100ps

module msps_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk_in,
   input wire logic global_reset_n_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   // ***************************************************************
   // Two-flop synchronisers, one per lane
   // ***************************************************************
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_lane
         logic meta_reg;
         // First flop feeds only the second; cleared without the clock
         always_ff @(posedge clk_in or negedge global_reset_n_in)
         begin
            if (!global_reset_n_in)
            begin
               meta_reg <= 1'b0;
               q_out[i] <= 1'b0;
            end
            else
            begin
               meta_reg <= d_in[i];
               q_out[i] <= meta_reg;
            end
         end
      end
   endgenerate

endmodule

// ---- msps_strap_latch.sv ----
`timescale 1ns/100ps

module msps_strap_latch
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk_in,
   input wire logic global_reset_n_in,
   input wire logic clear_in,
   input wire logic sample_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);

   // ***************************************************************
   // Hold register for sampled straps
   // ***************************************************************
   // Only a sample strobe or a clear changes the value, so later pin wiggles are ignored
   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         q_out <= '0;
      end
      else if (clear_in)
      begin
         q_out <= '0;
      end
      else if (sample_in)
      begin
         q_out <= d_in;
      end
   end

endmodule

// ---- msps_top.sv ----
// Function
// - Third general pin carries serial-bus data when SCL pull-up sensed or force bit set.
// - Fourth general pin carries serial-bus clock under that same condition.
// - Fourth pin internal pull-up on only during reset or when configured as input.
// - Global reset low asynchronously resets all logic and state machines: fourth pin pull-up on, clock at 50 MHz, all else cleared.
// - Clock speed strap picks default PCI clock: low gives 50 MHz, high 66 MHz.
// - The M66EN level also shapes the resulting PCI clock frequency.
// - Serial IRQ enabled if pull-up sensed at link reset release, disabled on pull-down.
// - Straps are sampled at global reset release and held inside.
// - Link reset is a reset source beside global reset and power-on reset.
`timescale 1ns/100ps
`include "msps_consts.svh"

module msps_top
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic global_reset_n_in,
   input wire logic link_reset_n_in,
   // Register port
   input wire logic [`MSPS_AW-1:0] addr_in,
   input wire logic [`MSPS_DW-1:0] wr_data_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   output logic [`MSPS_DW-1:0] rd_data_out,
   // Shared terminals
   input wire logic general_io_three_in,
   output logic general_io_three_out,
   output logic general_io_three_oe_out,
   input wire logic general_io_four_in,
   output logic general_io_four_out,
   output logic general_io_four_oe_out,
   output logic general_io_four_pullup_en_out,
   // Strap terminals
   input wire logic pci_clock_speed_strap_in,
   input wire logic pci_m66en_in,
   input wire logic serial_irq_pin_in,
   // Serial-bus controller side
   input wire logic sb_data_drive_low_in,
   input wire logic sb_clock_drive_low_in,
   output logic sb_data_out,
   output logic sb_clock_out,
   // Resulting selections
   output logic serial_bus_mode_out,
   output logic pci_clock_sel_66_out,
   output logic [`MSPS_MHZ_W-1:0] pci_clock_mhz_out,
   output logic serial_irq_en_out,
   output logic straps_valid_out
);
   import msps_pkg::*;

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic [`MSPS_SYNC_W-1:0] sync_d;
   logic [`MSPS_SYNC_W-1:0] sync_q;
   logic in_reset;
   msps_phase_t phase_reg;
   msps_phase_t phase_next;
   msps_strap_t strap_live;
   msps_strap_t strap_held;
   logic serial_irq_pin_held;
   logic link_prev_reg;
   logic link_release;
   logic link_clear;
   logic force_detect_reg;
   logic [`MSPS_GPIO_W-1:0] gpio_dir_reg;
   logic [`MSPS_GPIO_W-1:0] gpio_out_reg;
   logic sb_mode;
   msps_pin_t io3_next;
   msps_pin_t io4_next;
   logic [`MSPS_DW-1:0] rd_next;
   logic [`MSPS_DW-1:0] status_word;

   // ***************************************************************
   // Address decode helper
   // ***************************************************************
   function automatic logic addr_is(input logic [`MSPS_AW-1:0] a,
                                    input logic [`MSPS_AW-1:0] off);
      addr_is = (a == off);
   endfunction

   // ***************************************************************
   // Input synchronisers
   // ***************************************************************
   // Every pin and the reset release pass two flops first
   assign sync_d[`MSPS_SY_GLOBAL_RESET_N] = 1'b1;
   assign sync_d[`MSPS_SY_IO3] = general_io_three_in;
   assign sync_d[`MSPS_SY_IO4] = general_io_four_in;
   assign sync_d[`MSPS_SY_CLK66] = pci_clock_speed_strap_in;
   assign sync_d[`MSPS_SY_M66EN] = pci_m66en_in;
   assign sync_d[`MSPS_SY_SERIAL_IRQ_PIN] = serial_irq_pin_in;
   assign sync_d[`MSPS_SY_LRST] = link_reset_n_in;

   msps_sync #(
      .WIDTH(`MSPS_SYNC_W)
   ) u_sync (
      .clk_in(clk_in),
      .global_reset_n_in(global_reset_n_in),
      .d_in(sync_d),
      .q_out(sync_q)
   );

   // ***************************************************************
   // Reset combination
   // ***************************************************************
   // reset sources combined
   // Global release is seen two edges late so no flop leaves reset on a runt pulse
   assign in_reset = !sync_q[`MSPS_SY_GLOBAL_RESET_N] || !resetn_in;
   assign link_clear = in_reset || !sync_q[`MSPS_SY_LRST];

   // ***************************************************************
   // Strap sampling phase
   // ***************************************************************
   // one sample after release
   always_comb
   begin
      phase_next = phase_reg;
      case (phase_reg)
         MSPS_HELD_RESET:
         begin
            phase_next = MSPS_SAMPLE;
         end
         MSPS_SAMPLE:
         begin
            phase_next = MSPS_RUN;
         end
         MSPS_RUN:
         begin
            phase_next = MSPS_RUN;
         end
         default:
         begin
            phase_next = MSPS_HELD_RESET;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         phase_reg <= MSPS_HELD_RESET;
      end
      else if (in_reset)
      begin
         phase_reg <= MSPS_HELD_RESET;
      end
      else
      begin
         phase_reg <= phase_next;
      end
   end

   // Live strap levels, already synchronised
   assign strap_live.scl_pullup = sync_q[`MSPS_SY_IO4];
   assign strap_live.clk66 = sync_q[`MSPS_SY_CLK66];
   assign strap_live.m66en = sync_q[`MSPS_SY_M66EN];

   msps_strap_latch #(
      .WIDTH(`MSPS_STRAP_W)
   ) u_strap (
      .clk_in(clk_in),
      .global_reset_n_in(global_reset_n_in),
      .clear_in(in_reset),
      .sample_in(phase_reg == MSPS_SAMPLE),
      .d_in(strap_live),
      .q_out(strap_held)
   );

   // ***************************************************************
   // Serial IRQ enable at link reset release
   // ***************************************************************
   // Previous link level for the release edge
   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         link_prev_reg <= `MSPS_BIT_CLR;
      end
      else
      begin
         link_prev_reg <= sync_q[`MSPS_SY_LRST];
      end
   end

   assign link_release = sync_q[`MSPS_SY_LRST] && !link_prev_reg && !in_reset;

   msps_strap_latch #(
      .WIDTH(1)
   ) u_serial_irq_pin (
      .clk_in(clk_in),
      .global_reset_n_in(global_reset_n_in),
      .clear_in(link_clear),
      .sample_in(link_release),
      .d_in(sync_q[`MSPS_SY_SERIAL_IRQ_PIN]),
      .q_out(serial_irq_pin_held)
   );

   // ***************************************************************
   // Register writes
   // ***************************************************************
   // control bits cleared without clock
   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         force_detect_reg <= `MSPS_FORCE_RST;
         gpio_dir_reg <= `MSPS_GPIO_RST;
         gpio_out_reg <= `MSPS_GPIO_RST;
      end
      else if (in_reset)
      begin
         force_detect_reg <= `MSPS_FORCE_RST;
         gpio_dir_reg <= `MSPS_GPIO_RST;
         gpio_out_reg <= `MSPS_GPIO_RST;
      end
      else if (wr_en_in)
      begin
         if (addr_is(addr_in, `MSPS_ADDR_CTRL))
         begin
            force_detect_reg <= wr_data_in[`MSPS_CTRL_FORCE_BIT];
         end
         else if (addr_is(addr_in, `MSPS_ADDR_GPIO_DIR))
         begin
            gpio_dir_reg <= wr_data_in[`MSPS_GPIO_W-1:0];
         end
         else if (addr_is(addr_in, `MSPS_ADDR_GPIO_OUT))
         begin
            gpio_out_reg <= wr_data_in[`MSPS_GPIO_W-1:0];
         end
      end
   end

   // ***************************************************************
   // Pin function select
   // ***************************************************************
   // serial-bus mode condition
   // same condition for clock pin
   // Strap part cannot move after sampling; only the force bit can switch later
   assign sb_mode = (strap_held.scl_pullup && phase_reg == MSPS_RUN) || force_detect_reg;

   // Serial bus is open drain: drive low only, else GPIO direction rules
   always_comb
   begin
      io3_next.out = gpio_out_reg[`MSPS_IO3_BIT];
      io3_next.oe = gpio_dir_reg[`MSPS_IO3_BIT];
      io4_next.out = gpio_out_reg[`MSPS_IO4_BIT];
      io4_next.oe = gpio_dir_reg[`MSPS_IO4_BIT];
      if (sb_mode)
      begin
         io3_next.out = `MSPS_BIT_CLR;
         io3_next.oe = sb_data_drive_low_in;
         io4_next.out = `MSPS_BIT_CLR;
         io4_next.oe = sb_clock_drive_low_in;
      end
      // Nothing driven while held in reset, so straps read cleanly
      if (in_reset)
      begin
         io3_next.oe = `MSPS_BIT_CLR;
         io4_next.oe = `MSPS_BIT_CLR;
      end
   end

   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         general_io_three_out <= `MSPS_BIT_CLR;
         general_io_three_oe_out <= `MSPS_BIT_CLR;
         general_io_four_out <= `MSPS_BIT_CLR;
         general_io_four_oe_out <= `MSPS_BIT_CLR;
      end
      else
      begin
         general_io_three_out <= io3_next.out;
         general_io_three_oe_out <= io3_next.oe;
         general_io_four_out <= io4_next.out;
         general_io_four_oe_out <= io4_next.oe;
      end
   end

   // pull-up in reset or input
   // Pull-up also lets the SCL strap read high when nothing is fitted off chip
   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         general_io_four_pullup_en_out <= `MSPS_BIT_SET;
      end
      else
      begin
         general_io_four_pullup_en_out <= in_reset || !gpio_dir_reg[`MSPS_IO4_BIT];
      end
   end

   // Pin levels back to the serial-bus controller
   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         sb_data_out <= `MSPS_BIT_CLR;
         sb_clock_out <= `MSPS_BIT_CLR;
      end
      else
      begin
         sb_data_out <= sync_q[`MSPS_SY_IO3];
         sb_clock_out <= sync_q[`MSPS_SY_IO4];
      end
   end

   // ***************************************************************
   // Clock speed and selection outputs
   // ***************************************************************
   // strap picks 50 or 66
   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         pci_clock_sel_66_out <= `MSPS_BIT_CLR;
         pci_clock_mhz_out <= `MSPS_PCLK_LOW_MHZ;
         serial_bus_mode_out <= `MSPS_BIT_CLR;
         serial_irq_en_out <= `MSPS_BIT_CLR;
         straps_valid_out <= `MSPS_BIT_CLR;
      end
      else
      begin
         pci_clock_sel_66_out <= strap_held.clk66 && strap_held.m66en;
         if (strap_held.clk66 && strap_held.m66en)
         begin
            pci_clock_mhz_out <= `MSPS_PCLK_HIGH_MHZ;
         end
         else
         begin
            pci_clock_mhz_out <= `MSPS_PCLK_LOW_MHZ;
         end
         serial_bus_mode_out <= sb_mode;
         serial_irq_en_out <= serial_irq_pin_held;
         straps_valid_out <= (phase_reg == MSPS_RUN);
      end
   end

   // ***************************************************************
   // Register reads
   // ***************************************************************
   // Status gathers held straps and resulting selections
   always_comb
   begin
      status_word = `MSPS_DATA_ZERO;
      status_word[`MSPS_ST_SCL_PULLUP] = strap_held.scl_pullup;
      status_word[`MSPS_ST_CLK66_STRAP] = strap_held.clk66;
      status_word[`MSPS_ST_M66EN] = strap_held.m66en;
      status_word[`MSPS_ST_SB_MODE] = sb_mode;
      status_word[`MSPS_ST_SERIAL_IRQ_PIN_EN] = serial_irq_pin_held;
      status_word[`MSPS_ST_VALID] = (phase_reg == MSPS_RUN);
      status_word[`MSPS_ST_MHZ_HI:`MSPS_ST_MHZ_LO] = pci_clock_mhz_out;
   end

   // Unmapped addresses read zero
   always_comb
   begin
      rd_next = `MSPS_DATA_ZERO;
      if (addr_is(addr_in, `MSPS_ADDR_CTRL))
      begin
         rd_next[`MSPS_CTRL_FORCE_BIT] = force_detect_reg;
      end
      else if (addr_is(addr_in, `MSPS_ADDR_GPIO_DIR))
      begin
         rd_next[`MSPS_GPIO_W-1:0] = gpio_dir_reg;
      end
      else if (addr_is(addr_in, `MSPS_ADDR_GPIO_OUT))
      begin
         rd_next[`MSPS_GPIO_W-1:0] = gpio_out_reg;
      end
      else if (addr_is(addr_in, `MSPS_ADDR_GPIO_IN))
      begin
         rd_next[`MSPS_IO3_BIT] = sync_q[`MSPS_SY_IO3];
         rd_next[`MSPS_IO4_BIT] = sync_q[`MSPS_SY_IO4];
      end
      else if (addr_is(addr_in, `MSPS_ADDR_STATUS))
      begin
         rd_next = status_word;
      end
   end

   // Read data stand one cycle, zero otherwise
   always_ff @(posedge clk_in or negedge global_reset_n_in)
   begin
      if (!global_reset_n_in)
      begin
         rd_data_out <= `MSPS_DATA_ZERO;
      end
      else if (rd_en_in)
      begin
         rd_data_out <= rd_next;
      end
      else
      begin
         rd_data_out <= `MSPS_DATA_ZERO;
      end
   end

endmodule

// ---- msps_props.sv ----
`timescale 1ns/100ps
`include "msps_consts.svh"
// ********
// Strap and pin function checks
// ********
module msps_props
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic global_reset_n_in,
   input wire logic link_reset_n_in,
   input wire logic general_io_three_out,
   input wire logic general_io_three_oe_out,
   input wire logic general_io_four_out,
   input wire logic general_io_four_oe_out,
   input wire logic general_io_four_pullup_en_out,
   input wire logic sb_data_drive_low_in,
   input wire logic serial_bus_mode_out,
   input wire logic pci_clock_sel_66_out,
   input wire logic [`MSPS_MHZ_W-1:0] pci_clock_mhz_out,
   input wire logic serial_irq_en_out,
   input wire logic straps_valid_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);

   // Two edges of steady mode, so registered pin drive has caught up
   sequence sb_steady;
      serial_bus_mode_out ##1 serial_bus_mode_out;
   endsequence
   sequence gpio_input;
      (general_io_four_pullup_en_out && !serial_bus_mode_out) [*2];
   endsequence
   sequence gpio_output;
      (general_io_four_oe_out && !serial_bus_mode_out) [*2];
   endsequence

   // Global reset low clears mode, valid and irq enable and turns the pull-up on at once, no clock needed
   chk_global_reset_n_clears: assert property (
      !global_reset_n_in |-> !serial_bus_mode_out && !straps_valid_out
      && !serial_irq_en_out && general_io_four_pullup_en_out)
      else $error("outputs not cleared under global reset");
   chk_mhz_follows: assert property (
      pci_clock_mhz_out == (pci_clock_sel_66_out ? `MSPS_PCLK_HIGH_MHZ : `MSPS_PCLK_LOW_MHZ))
      else $error("clock frequency does not match speed select");
   chk_sel_held: assert property (
      straps_valid_out ##1 straps_valid_out |-> $stable(pci_clock_sel_66_out))
      else $error("clock select moved after strap capture");
   chk_valid_rise: assert property (
      $rose(straps_valid_out) |-> global_reset_n_in && $past(global_reset_n_in, 3))
      else $error("straps valid without global reset release");
   chk_input_pullup: assert property (
      gpio_input |-> !general_io_four_oe_out)
      else $error("pull-up on while fourth pin drives");
   chk_output_nopull: assert property (
      gpio_output |-> !general_io_four_pullup_en_out)
      else $error("pull-up left on for output pin");
   chk_sb_quiet: assert property (
      sb_steady |-> !general_io_three_out && !general_io_four_out)
      else $error("serial-bus pins drive high");
   chk_sb_data_oe: assert property (
      sb_steady |-> general_io_three_oe_out == $past(sb_data_drive_low_in))
      else $error("data pin enable not following controller");
   chk_link_clears: assert property (
      (!link_reset_n_in) [*5] |-> !serial_irq_en_out)
      else $error("serial irq enabled during link reset");
   chk_irq_rise: assert property (
      $rose(serial_irq_en_out) |-> link_reset_n_in)
      else $error("serial irq enabled while link reset low");
endmodule

bind msps_top msps_props msps_props_inst
(
   .clk_in(clk_in),
   .resetn_in(resetn_in),
   .global_reset_n_in(global_reset_n_in),
   .link_reset_n_in(link_reset_n_in),
   .general_io_three_out(general_io_three_out),
   .general_io_three_oe_out(general_io_three_oe_out),
   .general_io_four_out(general_io_four_out),
   .general_io_four_oe_out(general_io_four_oe_out),
   .general_io_four_pullup_en_out(general_io_four_pullup_en_out),
   .sb_data_drive_low_in(sb_data_drive_low_in),
   .serial_bus_mode_out(serial_bus_mode_out),
   .pci_clock_sel_66_out(pci_clock_sel_66_out),
   .pci_clock_mhz_out(pci_clock_mhz_out),
   .serial_irq_en_out(serial_irq_en_out),
   .straps_valid_out(straps_valid_out)
);

// ---- msps_board.sv ----
`timescale 1ns/100ps
// ********
// Board resistors on the shared and strap pins
// ********
module msps_board
(
   input wire logic [3:0] strap_set_in,
   input wire logic io3_drv_in,
   input wire logic io3_oe_in,
   input wire logic io4_drv_in,
   input wire logic io4_oe_in,
   output logic io3_pin_out,
   output logic io4_pin_out,
   output logic clk66_pin_out,
   output logic m66en_pin_out,
   output logic irq_pin_out
);
   // Bit 3 fits pull-ups on both bus pins, else pull-downs
   // Board resistor beats the weak internal pull-up, so it is ignored here
   assign io3_pin_out = io3_oe_in ? io3_drv_in : strap_set_in[3];
   assign io4_pin_out = io4_oe_in ? io4_drv_in : strap_set_in[3];
   // Strap pins always sit on their resistor
   assign clk66_pin_out = strap_set_in[2];
   assign m66en_pin_out = strap_set_in[1];
   assign irq_pin_out = strap_set_in[0];
endmodule

// ---- msps_top_tb_top.sv ----
`timescale 1ns/100ps
`include "msps_consts.svh"
module msps_top_tb_top;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic glob_rst_n = 1'b0;
   logic link_rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic dl_data = 1'b0;
   logic dl_clk = 1'b0;
   logic [3:0] straps = 4'h0;
   logic io3_out, io3_oe, io4_out, io4_oe, pull_en, io3_pin, io4_pin, c66_pin, m66_pin, irq_pin;
   logic sb_data, sb_clk, sb_mode, sel66, irq_en, valid;
   logic [6:0] mhz;
   logic [3:0] combos [4] = '{4'b0100, 4'b1111, 4'b0010, 4'b0111};
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;

   // ********
   // Clock, parts and tasks
   // ********
   always #5 clk_in = ~clk_in;

   msps_board msps_board_inst (.strap_set_in(straps), .io3_drv_in(io3_out), .io3_oe_in(io3_oe),
      .io4_drv_in(io4_out), .io4_oe_in(io4_oe), .io3_pin_out(io3_pin), .io4_pin_out(io4_pin),
      .clk66_pin_out(c66_pin), .m66en_pin_out(m66_pin), .irq_pin_out(irq_pin));

   msps_top msps_top_inst (.clk_in(clk_in), .resetn_in(resetn_in),
      .global_reset_n_in(glob_rst_n), .link_reset_n_in(link_rst_n), .addr_in(addr),
      .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rdata),
      .general_io_three_in(io3_pin), .general_io_three_out(io3_out),
      .general_io_three_oe_out(io3_oe), .general_io_four_in(io4_pin),
      .general_io_four_out(io4_out), .general_io_four_oe_out(io4_oe),
      .general_io_four_pullup_en_out(pull_en), .pci_clock_speed_strap_in(c66_pin),
      .pci_m66en_in(m66_pin), .serial_irq_pin_in(irq_pin), .sb_data_drive_low_in(dl_data),
      .sb_clock_drive_low_in(dl_clk), .sb_data_out(sb_data), .sb_clock_out(sb_clk),
      .serial_bus_mode_out(sb_mode), .pci_clock_sel_66_out(sel66), .pci_clock_mhz_out(mhz),
      .serial_irq_en_out(irq_en), .straps_valid_out(valid));

   task automatic close_out();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk_in);
      wr_en <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_in);
      rd_en <= 1'b0;
      #1 check("rd_data", exp, rdata);
      // Return on an edge so callers drive on the edge too
      @(posedge clk_in);
   endtask

   // Global reset dropped on an edge, outputs checked before the next one
   task automatic global_reset_n(input logic [3:0] s);
      int i;
      @(posedge clk_in);
      glob_rst_n <= 1'b0;
      link_rst_n <= 1'b0;
      straps <= s;
      #1 check("pullup_async", 1, pull_en);
      check("mode_async", 0, sb_mode);
      check("valid_async", 0, valid);
      check("mhz_async", 32'h32, mhz);
      tick(3);
      glob_rst_n <= 1'b1;
      for (i = 0; i < 20 && valid !== 1'b1; i++)
         @(posedge clk_in);
      check("valid", 1, valid);
      link_rst_n <= 1'b1;
      tick(6);
   endtask

   // Hang guard, well above the fewer than two hundred cycles the tests need
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 2000)
      begin
         n_mismatch++;
         close_out();
      end
   end

   // ********
   // Test sequence
   // ********
   initial
   begin
      logic [3:0] s;
      logic [6:0] m;
      tick(6);
      resetn_in <= 1'b1;
      // Four strap mixes, then straps flipped behind the captured values
      for (int i = 0; i < 4; i++)
      begin
         s = combos[i];
         m = (s[2] & s[1]) ? 7'h42 : 7'h32;
         global_reset_n(s);
         check("sb_mode", s[3], sb_mode);
         check("sel66", s[2] & s[1], sel66);
         check("mhz", m, mhz);
         check("irq_en", s[0], irq_en);
         rd(8'h10, {17'h0, m, 2'b00, 1'b1, s[0], s[3], s[1], s[2], s[3]});
         // Straps flipped on an edge, after the read has returned
         dl_data <= 1'b1;
         straps <= ~s;
         tick(5);
         check("io3_oe", s[3], io3_oe);
         check("sel66_held", s[2] & s[1], sel66);
         check("sb_held", s[3], sb_mode);
         dl_data <= 1'b0;
      end
      // Irq pin level at link reset release decides the serial irq enable
      for (int j = 0; j < 2; j++)
      begin
         straps <= {3'b011, j[0]};
         link_rst_n <= 1'b0;
         tick(6);
         check("irq_link_low", 0, irq_en);
         link_rst_n <= 1'b1;
         tick(6);
         check("irq_after_link", j[0], irq_en);
      end
      // Plain general-purpose use, both pins driven
      wr(8'h04, 32'h3);
      wr(8'h08, 32'h2);
      tick(3);
      check("pin_drive", 32'he, {io4_oe, io4_out, io3_oe, io3_out});
      check("pullup_out", 0, pull_en);
      rd(8'h04, 32'h3);
      rd(8'h0c, 32'h2);
      check("sb_lines", 32'h2, {sb_clk, sb_data});
      // Software force overrides the general-purpose settings
      wr(8'h08, 32'h3);
      dl_data <= 1'b1;
      dl_clk <= 1'b1;
      wr(8'h00, 32'h1);
      tick(4);
      check("force_mode", 1, sb_mode);
      check("force_drive", 32'ha, {io4_oe, io4_out, io3_oe, io3_out});
      rd(8'h00, 32'h1);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0);
      dl_data <= 1'b0;
      dl_clk <= 1'b0;
      tick(4);
      // Output levels keep the register value, only the enables drop
      check("release_drive", 32'h5, {io4_oe, io4_out, io3_oe, io3_out});
      check("pullup_in", 1, pull_en);
      check("mode_off", 0, sb_mode);
      rd(8'h0c, 32'h0);
      rd(8'h20, 32'h0);
      close_out();
   end
endmodule
